// ==== plcs_line_master.sv ====
// partner model: the charging-case master that polls the slave and sends requests
// assumes the register bank's line-side ports and one shared core clock
`timescale 1ns/1ps

module plcs_line_master
  import plcs_pkg::*;
(
  // clock
  input  wire logic                     core_clk,
  // slave answers
  input  wire logic                     cmd_send,
  input  wire plcs_pkg::plcs_cmd_t      cmd_out,
  input  wire logic [7:0]               send_bytes,
  input  wire logic                     resp_valid,
  input  wire logic                     resp_nack,
  // master drive
  output logic                          line_poll,
  output logic                          cmd_done,
  output logic                          rx_done,
  output logic [6:0]                    rx_count_m1,
  output plcs_pkg::plcs_line_req_t      line_req
);
  int unsigned sent_cnt = 0;
  int unsigned resp_cnt = 0;
  plcs_cmd_t   last_cmd;
  logic [7:0]  last_bytes;
  logic        last_nack;

  // idle line levels
  initial
  begin
    line_poll   = 1'b0;
    cmd_done    = 1'b0;
    rx_done     = 1'b0;
    rx_count_m1 = 7'h55;
    line_req    = '{1'b0, 7'h2A, 8'h55};
  end

  // capture every command sent and every answer given
  always @(posedge core_clk)
  begin
    if (cmd_send)
    begin
      sent_cnt   <= sent_cnt + 1;
      last_cmd   <= cmd_out;
      last_bytes <= send_bytes;
    end
    if (resp_valid)
    begin
      resp_cnt  <= resp_cnt + 1;
      last_nack <= resp_nack;
    end
  end

  // one poll slot on the line
  task automatic poll();
    @(negedge core_clk) line_poll = 1'b1;
    @(negedge core_clk) line_poll = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // master request; any code and argument given are sent, with no check
  task automatic request(input logic [6:0] code, input logic [7:0] arg);
    @(negedge core_clk) line_req = '{1'b1, code, arg};
    @(negedge core_clk) line_req = '{1'b0, ~code, ~arg}; // released: inverse of last value
    repeat (2) @(negedge core_clk);
  endtask

  // command-done event from the line layer
  task automatic done_pulse();
    @(negedge core_clk) cmd_done = 1'b1;
    @(negedge core_clk) cmd_done = 1'b0;
  endtask

  // completed data-out reception with its byte count minus one
  task automatic receive(input logic [6:0] cnt);
    @(negedge core_clk)
    begin
      rx_done     = 1'b1;
      rx_count_m1 = cnt;
    end
    @(negedge core_clk)
    begin
      rx_done     = 1'b0;
      rx_count_m1 = ~cnt;
    end
  endtask
endmodule // plcs_line_master

// ==== plcs_pkg.sv ====
// package for the power-line slave command register bank
// assumes a byte-wide register port driven by an external i2c slave decoder
package plcs_pkg;

  // register offsets
  localparam logic [7:0] PLCS_ADDR_REFUSAL = 8'h36;
  localparam logic [7:0] PLCS_ADDR_ARG     = 8'h37;
  localparam logic [7:0] PLCS_ADDR_CMD     = 8'h38;
  localparam logic [7:0] PLCS_ADDR_RXCNT   = 8'h39;

  // refusal config and command register field positions
  localparam int PLCS_BIT_NO_FIFO   = 7;
  localparam int PLCS_BIT_NO_SEAL   = 6;
  localparam int PLCS_BIT_NO_SERIAL = 5;
  localparam int PLCS_BIT_NO_IDLE   = 4;
  localparam int PLCS_BIT_SWAP      = 0;
  localparam int PLCS_BIT_RUN       = 7;

  // reset values
  localparam logic [7:0] PLCS_RST_REFUSAL = 8'h20;
  localparam logic [7:0] PLCS_RST_ARG     = 8'h00;
  localparam logic [6:0] PLCS_RST_CODE    = 7'h00;
  localparam logic [6:0] PLCS_RST_RXCNT   = 7'h00;

  // command codes
  localparam logic [6:0] PLCS_CMD_SYSREQ  = 7'h00;
  localparam logic [6:0] PLCS_CMD_PINSET  = 7'h03;
  localparam logic [6:0] PLCS_CMD_DATAOUT = 7'h05;
  localparam logic [6:0] PLCS_CMD_SERIAL  = 7'h06;

  // system request arguments
  localparam logic [7:0] PLCS_SYS_SOFTRST = 8'h01;
  localparam logic [7:0] PLCS_SYS_GAUGE   = 8'h03;
  localparam logic [7:0] PLCS_SYS_FIFO    = 8'h04;
  localparam logic [7:0] PLCS_SYS_FREE    = 8'h05;
  localparam logic [7:0] PLCS_SYS_IDLE    = 8'h06;
  localparam logic [7:0] PLCS_SYS_SEAL    = 8'h07;

  // serial bypass arguments
  localparam logic [7:0] PLCS_SER_MANUAL  = 8'h00;
  localparam logic [7:0] PLCS_SER_C1_TX   = 8'h01;
  localparam logic [7:0] PLCS_SER_C1_RX   = 8'h02;
  localparam logic [7:0] PLCS_SER_C2_TX   = 8'h04;
  localparam logic [7:0] PLCS_SER_C2_RX   = 8'h06;
  localparam logic [7:0] PLCS_SER_C2_LOOP = 8'h07;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } plcs_reg_req_t;

  // command handed to the line
  typedef struct packed {
    logic [6:0] code;
    logic [7:0] arg;
  } plcs_cmd_t;

  // master request arriving on the line
  typedef struct packed {
    logic       valid;
    logic [6:0] code;
    logic [7:0] arg;
  } plcs_line_req_t;

  // serial switch setting
  typedef struct packed {
    logic       manual;
    logic       chan2;
    logic       tx_on;
    logic       rx_on;
  } plcs_serial_t;

endpackage

// ==== plcs_regs.sv ====
// power-line slave command registers: refusal config, argument, trigger, rx count
// assumes a register port from an i2c slave and a line layer reporting polls,
// incoming master requests and completed data-out receptions
//
// Function
// - fifo refusal bit nacks fifo system request
// - seal refusal bit nacks seal system request
// - serial refusal bit nacks serial bypass; resets set
// - idle refusal bit nacks idle system request
// - swap bit maps outgoing mailbox for readback
// - pin argument: resistor enables high, levels low
// - data-out sends argument plus one bytes
// - serial args 0,1,2 select manual, ch1 tx/rx
// - serial args 4,6,7 select ch2 tx/rx/loop
// - system request argument codes 1,3,4,5,6,7
// - writing run bit starts held command
// - run bit reads one until sent on poll
// - command codes 0,3,5,6 defined
// - rx count reports last byte count minus one
// - rx count updates with the new-data event only
// - full flag set nacks new data-out requests
// - continuous stream resends after each command done once a data-out has been sent
`timescale 1ns/1ps

module plcs_regs
  import plcs_pkg::*;
(
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // register port
  input  wire plcs_pkg::plcs_reg_req_t  reg_req,
  output logic [7:0]                    reg_rdata,
  // mailbox and stream status from the bulk/mailbox logic
  input  wire logic                     buffer_full_flag,
  input  wire logic                     cont_stream,
  // line side: poll, command done, received data-out
  input  wire logic                     line_poll,
  input  wire logic                     cmd_done,
  input  wire logic                     rx_done,
  input  wire logic [6:0]               rx_count_m1,
  input  wire plcs_pkg::plcs_line_req_t line_req,
  // line side outputs
  output logic                          cmd_send,
  output plcs_pkg::plcs_cmd_t           cmd_out,
  output logic [7:0]                    send_bytes,
  output logic                          resp_valid,
  output logic                          resp_nack,
  // decoded controls
  output logic                          mailbox_readback,
  output logic [3:0]                    pin_resistor_enable,
  output logic [3:0]                    pin_output_level,
  output logic                          pin_update,
  output plcs_pkg::plcs_serial_t        serial_cfg,
  output logic                          sys_action,
  output logic [7:0]                    sys_action_code
);
  import plcs_pkg::*;

  logic          rst_s1_q;
  logic          rst_s2_q;
  logic [7:0]    refusal_q;
  logic [7:0]    arg_q;
  logic [6:0]    code_q;
  logic          run_q;
  logic [6:0]    rxcnt_q;
  logic          stream_arm_q;
  logic          wr_refusal;
  logic          wr_arg;
  logic          wr_cmd;
  logic          send_now;
  logic          nack_d;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // write decode
  assign wr_refusal = reg_req.wr && (reg_req.addr == PLCS_ADDR_REFUSAL);
  assign wr_arg     = reg_req.wr && (reg_req.addr == PLCS_ADDR_ARG) && !run_q;
  assign wr_cmd     = reg_req.wr && (reg_req.addr == PLCS_ADDR_CMD);
  assign send_now   = run_q && line_poll;

  // refusal config, bits 3..1 reserved
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      refusal_q <= PLCS_RST_REFUSAL;
    else if (wr_refusal)
      refusal_q <= reg_req.wdata & 8'hF1;
  end

  // command argument
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      arg_q <= PLCS_RST_ARG;
    else if (wr_arg)
      arg_q <= reg_req.wdata;
  end

  // command code, frozen while a command is pending
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      code_q <= PLCS_RST_CODE;
    else if (wr_cmd && !run_q)
      code_q <= reg_req.wdata[6:0];
  end

  // run trigger: set by write of one, cleared when sent; set wins
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      run_q <= 1'b0;
    else if (wr_cmd && reg_req.wdata[PLCS_BIT_RUN])
      run_q <= 1'b1;
    else if (stream_arm_q && cmd_done && cont_stream)
      run_q <= 1'b1;
    else if (send_now)
      run_q <= 1'b0;
  end

  // continuous stream: armed by a data-out send
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      stream_arm_q <= 1'b0;
    else if (!cont_stream)
      stream_arm_q <= 1'b0;
    else if (send_now && code_q == PLCS_CMD_DATAOUT)
      stream_arm_q <= 1'b1;
  end

  // received byte count, updated with the new-data event
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      rxcnt_q <= PLCS_RST_RXCNT;
    else if (rx_done)
      rxcnt_q <= rx_count_m1;
  end

  // command out to the line on poll
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      cmd_send   <= 1'b0;
      cmd_out    <= '0;
      send_bytes <= 8'h00;
    end
    else
    begin
      cmd_send <= send_now;
      if (send_now)
      begin
        cmd_out.code <= code_q;
        cmd_out.arg  <= arg_q;
        send_bytes   <= (code_q == PLCS_CMD_DATAOUT) ? 8'(arg_q + 8'h01) : 8'h00;
      end
    end
  end

  // acceptance decision for master requests
  always_comb
  begin
    nack_d = 1'b0;
    case (line_req.code)
      PLCS_CMD_SYSREQ:
      begin
        if (line_req.arg == PLCS_SYS_FIFO && refusal_q[PLCS_BIT_NO_FIFO])
          nack_d = 1'b1;
        if (line_req.arg == PLCS_SYS_SEAL && refusal_q[PLCS_BIT_NO_SEAL])
          nack_d = 1'b1;
        if (line_req.arg == PLCS_SYS_IDLE && refusal_q[PLCS_BIT_NO_IDLE])
          nack_d = 1'b1;
      end
      PLCS_CMD_SERIAL:  nack_d = refusal_q[PLCS_BIT_NO_SERIAL];
      PLCS_CMD_DATAOUT: nack_d = buffer_full_flag;
      default:          nack_d = 1'b0;
    endcase
  end

  // response to master requests
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      resp_valid <= 1'b0;
      resp_nack  <= 1'b0;
    end
    else
    begin
      resp_valid <= line_req.valid;
      resp_nack  <= line_req.valid && nack_d;
    end
  end

  // decode of accepted master requests into actions
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      pin_resistor_enable <= 4'h0;
      pin_output_level    <= 4'h0;
      pin_update          <= 1'b0;
      serial_cfg          <= '{manual: 1'b1, default: 1'b0};
      sys_action          <= 1'b0;
      sys_action_code     <= 8'h00;
    end
    else
    begin
      pin_update <= 1'b0;
      sys_action <= 1'b0;
      if (line_req.valid && !nack_d)
      begin
        case (line_req.code)
          PLCS_CMD_PINSET:
          begin
            pin_resistor_enable <= line_req.arg[7:4];
            pin_output_level    <= line_req.arg[3:0];
            pin_update          <= 1'b1;
          end
          PLCS_CMD_SERIAL:
          begin
            case (line_req.arg)
              PLCS_SER_C1_TX:   serial_cfg <= '{manual: 1'b0, chan2: 1'b0, tx_on: 1'b0, rx_on: 1'b1};
              PLCS_SER_C1_RX:   serial_cfg <= '{manual: 1'b0, chan2: 1'b0, tx_on: 1'b1, rx_on: 1'b0};
              PLCS_SER_C2_TX:   serial_cfg <= '{manual: 1'b0, chan2: 1'b1, tx_on: 1'b0, rx_on: 1'b1};
              PLCS_SER_C2_RX:   serial_cfg <= '{manual: 1'b0, chan2: 1'b1, tx_on: 1'b1, rx_on: 1'b0};
              PLCS_SER_C2_LOOP: serial_cfg <= '{manual: 1'b0, chan2: 1'b1, tx_on: 1'b1, rx_on: 1'b1};
              default:          serial_cfg <= '{manual: 1'b1, default: 1'b0};
            endcase
          end
          PLCS_CMD_SYSREQ:
          begin
            sys_action      <= 1'b1;
            sys_action_code <= line_req.arg;
          end
          default:
          begin
            pin_update <= 1'b0;
          end
        endcase
      end
    end
  end

  // readback and mailbox swap
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      reg_rdata        <= 8'h00;
      mailbox_readback <= 1'b0;
    end
    else
    begin
      mailbox_readback <= refusal_q[PLCS_BIT_SWAP];
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          PLCS_ADDR_REFUSAL: reg_rdata <= refusal_q;
          PLCS_ADDR_ARG:     reg_rdata <= arg_q;
          PLCS_ADDR_CMD:     reg_rdata <= {run_q, code_q};
          PLCS_ADDR_RXCNT:   reg_rdata <= {1'b0, rxcnt_q};
          default:           reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // checks
  chk_run_poll_clear: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (run_q && line_poll && !wr_cmd && !cmd_done) |=> !run_q && cmd_send)
    else $error("run bit not cleared after poll send");
  chk_run_write_set: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (wr_cmd && reg_req.wdata[7]) |=> run_q)
    else $error("run bit not set by write");
  chk_zero_write_noop: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (!run_q && !(wr_cmd && reg_req.wdata[7]) && !(stream_arm_q && cmd_done && cont_stream)) |=> !run_q)
    else $error("run bit set without trigger");
  chk_pending_code_held: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    run_q |=> $stable(code_q) && $stable(arg_q))
    else $error("pending command changed");
  chk_full_nacks_dout: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (line_req.valid && line_req.code == 7'h05 && buffer_full_flag) |=> resp_valid && resp_nack)
    else $error("data-out not refused while full");
  chk_serial_refused: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (line_req.valid && line_req.code == 7'h06) |=> resp_nack == $past(refusal_q[5]))
    else $error("serial refusal mismatch");
  chk_fifo_refused: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (line_req.valid && line_req.code == 7'h00 && line_req.arg == 8'h04) |=> resp_nack == $past(refusal_q[7]))
    else $error("fifo refusal mismatch");
  chk_idle_refused: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (line_req.valid && line_req.code == 7'h00 && line_req.arg == 8'h06) |=> resp_nack == $past(refusal_q[4]))
    else $error("idle refusal mismatch");
  chk_seal_refused: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (line_req.valid && line_req.code == 7'h00 && line_req.arg == 8'h07) |=> resp_nack == $past(refusal_q[6]))
    else $error("seal refusal mismatch");
  chk_rxcnt_update: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    rx_done |=> rxcnt_q == $past(rx_count_m1))
    else $error("rx count not updated");
  chk_dout_bytes: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
    (send_now && code_q == 7'h05) |=> send_bytes == 8'($past(arg_q) + 8'h01))
    else $error("data-out byte count wrong");

  cov_cmd_sent: cover property (@(posedge core_clk) disable iff (!rst_s2_q) wr_cmd ##[1:20] cmd_send);
  cov_dout_nack: cover property (@(posedge core_clk) disable iff (!rst_s2_q) resp_valid && resp_nack);
  cov_stream: cover property (@(posedge core_clk) disable iff (!rst_s2_q) stream_arm_q && cmd_done && cont_stream);

endmodule // plcs_regs

// ==== power_line_slave_command_regs_tb.sv ====
// self-checking bench for the power-line slave command register bank
// assumes plcs_regs with byte register port; drives inputs on the falling edge
`timescale 1ns/1ps

`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin failures++; $display("Error %0t: %s", $time, m); end end

module power_line_slave_command_regs_tb;
  import plcs_pkg::*;
  logic          core_clk = 1'b0;
  logic          rst_n    = 1'b0;
  plcs_reg_req_t reg_req  = '0;
  logic [7:0]    reg_rdata;
  logic          buffer_full_flag = 1'b0;
  logic          cont_stream      = 1'b0;
  logic          line_poll, cmd_done, rx_done, cmd_send, resp_valid, resp_nack;
  logic [6:0]    rx_count_m1;
  plcs_line_req_t line_req;
  plcs_cmd_t     cmd_out;
  logic [7:0]    send_bytes, sys_action_code;
  logic          mailbox_readback, pin_update, sys_action;
  logic [3:0]    pin_resistor_enable, pin_output_level;
  plcs_serial_t  serial_cfg;
  int            failures   = 0;
  int            num_checks = 0;
  int            cycles     = 0;
  int            sys_pulses = 0;
  int            pin_pulses = 0;
  int unsigned   n;
  logic [7:0]    sys_args [5] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06};

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  plcs_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .buffer_full_flag(buffer_full_flag), .cont_stream(cont_stream), .line_poll(line_poll),
    .cmd_done(cmd_done), .rx_done(rx_done), .rx_count_m1(rx_count_m1), .line_req(line_req),
    .cmd_send(cmd_send), .cmd_out(cmd_out), .send_bytes(send_bytes), .resp_valid(resp_valid),
    .resp_nack(resp_nack), .mailbox_readback(mailbox_readback),
    .pin_resistor_enable(pin_resistor_enable), .pin_output_level(pin_output_level),
    .pin_update(pin_update), .serial_cfg(serial_cfg), .sys_action(sys_action),
    .sys_action_code(sys_action_code));

  plcs_line_master mst_u (.core_clk(core_clk), .cmd_send(cmd_send), .cmd_out(cmd_out),
    .send_bytes(send_bytes), .resp_valid(resp_valid), .resp_nack(resp_nack),
    .line_poll(line_poll), .cmd_done(cmd_done), .rx_done(rx_done),
    .rx_count_m1(rx_count_m1), .line_req(line_req));

  // verdict and end of run
  task automatic conclude();
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard and counters of the one-cycle action pulses
  always @(posedge core_clk)
  begin
    cycles++;
    if (sys_action)
      sys_pulses++;
    if (pin_update)
      pin_pulses++;
    if (cycles == 5000)
    begin
      failures++;
      conclude();
    end
  end

  // one-cycle register write
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk) reg_req = '{1'b1, 1'b0, addr, data};
    @(negedge core_clk) reg_req = '{1'b0, 1'b0, addr, ~data};
  endtask

  // register read compared with an expected byte
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string m);
    @(negedge core_clk) reg_req = '{1'b0, 1'b1, addr, 8'h00};
    @(negedge core_clk) reg_req.rd = 1'b0;
    @(negedge core_clk) `CHK(reg_rdata, exp, m)
  endtask

  // line request under a given refusal setting, answer compared
  task automatic req_case(input logic [7:0] cfg, input logic [6:0] code, input logic [7:0] arg,
                          input logic exp);
    wr(PLCS_ADDR_REFUSAL, cfg);
    n = mst_u.resp_cnt;
    mst_u.request(code, arg);
    `CHK(mst_u.resp_cnt == n + 1, 1'b1, "no answer to line request")
    `CHK(mst_u.last_nack, exp, "wrong ack or nack")
  endtask

  // accepted serial bypass request and the resulting switch setting
  task automatic ser_case(input logic [7:0] arg, input logic [3:0] exp);
    req_case(8'h00, PLCS_CMD_SERIAL, arg, 1'b0);
    `CHK(serial_cfg, exp, "serial switch setting")
  endtask

  // command sent on the next poll, compared by code, argument and byte count
  task automatic poll_case(input logic [6:0] code, input logic [7:0] arg, input logic [7:0] bytes);
    n = mst_u.sent_cnt;
    mst_u.poll();
    `CHK(mst_u.sent_cnt == n + 1, 1'b1, "command not sent on poll")
    `CHK(mst_u.last_cmd, {code, arg}, "sent command")
    `CHK(mst_u.last_bytes, bytes, "sent byte count")
  endtask

  initial
  begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    // reset values and an unmapped address
    rd(PLCS_ADDR_REFUSAL, 8'h20, "refusal reset");
    rd(PLCS_ADDR_ARG, 8'h00, "argument reset");
    rd(PLCS_ADDR_CMD, 8'h00, "command reset");
    rd(PLCS_ADDR_RXCNT, 8'h00, "rx count reset");
    rd(8'h3A, 8'h00, "unmapped read");
    // refusal bits against the fifo, seal and idle system requests and the serial request
    req_case(8'h80, PLCS_CMD_SYSREQ, PLCS_SYS_FIFO, 1'b1);
    req_case(8'h00, PLCS_CMD_SYSREQ, PLCS_SYS_FIFO, 1'b0);
    req_case(8'h40, PLCS_CMD_SYSREQ, PLCS_SYS_SEAL, 1'b1);
    req_case(8'h00, PLCS_CMD_SYSREQ, PLCS_SYS_SEAL, 1'b0);
    req_case(8'h20, PLCS_CMD_SERIAL, PLCS_SER_C1_TX, 1'b1);
    req_case(8'h10, PLCS_CMD_SYSREQ, PLCS_SYS_IDLE, 1'b1);
    req_case(8'h00, PLCS_CMD_SYSREQ, PLCS_SYS_IDLE, 1'b0);
    // each system request code except seal (7) reaches the action output; three accepted ones came before, refused ones act not
    foreach (sys_args[i])
    begin
      req_case(8'h00, PLCS_CMD_SYSREQ, sys_args[i], 1'b0);
      `CHK(sys_action_code, sys_args[i], "system action code")
      `CHK(sys_pulses, i + 4, "system action pulse")
    end
    // serial bypass switch settings {manual, chan2, tx_on, rx_on}
    ser_case(PLCS_SER_C1_TX, 4'h1);
    ser_case(PLCS_SER_MANUAL, 4'h8);
    ser_case(PLCS_SER_C1_RX, 4'h2);
    ser_case(PLCS_SER_C2_TX, 4'h5);
    ser_case(PLCS_SER_C2_RX, 4'h6);
    ser_case(PLCS_SER_C2_LOOP, 4'h7);
    // full mailbox refuses data-out, empty one accepts
    buffer_full_flag = 1'b1;
    req_case(8'h00, PLCS_CMD_DATAOUT, 8'h03, 1'b1);
    buffer_full_flag = 1'b0;
    req_case(8'h00, PLCS_CMD_DATAOUT, 8'h03, 1'b0);
    // mailbox readback swap
    wr(PLCS_ADDR_REFUSAL, 8'h01);
    @(negedge core_clk); // swap output follows the register by one cycle
    `CHK(mailbox_readback, 1'b1, "swap set")
    wr(PLCS_ADDR_REFUSAL, 8'h00); // swap bit cleared again by writing zero
    @(negedge core_clk);
    `CHK(mailbox_readback, 1'b0, "swap clear")
    // pin command: pending until polled, locked against writes
    wr(PLCS_ADDR_ARG, 8'hA5);
    wr(PLCS_ADDR_CMD, {1'b1, PLCS_CMD_PINSET});
    rd(PLCS_ADDR_CMD, 8'h83, "run bit pending");
    wr(PLCS_ADDR_ARG, 8'h11);
    wr(PLCS_ADDR_CMD, {1'b0, PLCS_CMD_DATAOUT});
    rd(PLCS_ADDR_CMD, 8'h83, "command locked");
    `CHK(mst_u.sent_cnt, 0, "sent before poll")
    poll_case(PLCS_CMD_PINSET, 8'hA5, 8'h00);
    // pin outputs follow an accepted pin request from the master
    req_case(8'h00, PLCS_CMD_PINSET, 8'hA5, 1'b0);
    `CHK({pin_resistor_enable, pin_output_level}, 8'hA5, "pin fields")
    `CHK(pin_pulses, 1, "pin update pulse")
    rd(PLCS_ADDR_CMD, 8'h03, "run bit cleared");
    // data-out sends argument plus one bytes
    wr(PLCS_ADDR_ARG, 8'hFE);
    wr(PLCS_ADDR_CMD, {1'b1, PLCS_CMD_DATAOUT});
    poll_case(PLCS_CMD_DATAOUT, 8'hFE, 8'hFF);
    // received count at its top value
    mst_u.receive(7'h7F);
    rd(PLCS_ADDR_RXCNT, 8'h7F, "rx count");
    // continuous stream re-arms after command done
    cont_stream = 1'b1;
    wr(PLCS_ADDR_ARG, 8'h03);
    wr(PLCS_ADDR_CMD, {1'b1, PLCS_CMD_DATAOUT});
    poll_case(PLCS_CMD_DATAOUT, 8'h03, 8'h04);
    mst_u.done_pulse();
    rd(PLCS_ADDR_CMD, 8'h85, "stream re-armed");
    cont_stream = 1'b0;
    poll_case(PLCS_CMD_DATAOUT, 8'h03, 8'h04);
    rd(PLCS_ADDR_CMD, 8'h05, "stream ended");
    conclude();
  end
endmodule // power_line_slave_command_regs_tb
